// [bench/memctl_regs_asserts.sv]
// Checker for the register group ports.
// Assumes one clock domain, bound to the register block.
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Checker
module memctl_regs_asserts (
   // Clock and reset
   input wire logic clock_in,
   input wire logic arst_n_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic write_in,
   input wire logic read_in,
   input wire logic [31:0] rdata_out,
   // Events and outputs
   input wire logic illegal_access_in,
   input wire logic irq_out,
   input wire logic [2:0] read_latency_out,
   input wire logic strobe_gating_select_out,
   input wire logic [1:0] ref_level_select_out,
   input wire logic [2:0] drive_strength_out,
   input wire logic [2:0] filter_ctrl_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);
   sequence s_rd0; read_in && addr_in == 8'h00; endsequence
   sequence s_w1c(logic [7:0] a); write_in && addr_in == a && wdata_in[2] && !illegal_access_in; endsequence
   sequence s_wcal; write_in && addr_in == 8'h18; endsequence
   property p_count; s_rd0 ##3 s_rd0 |=> rdata_out == $past(rdata_out, 3) + 32'h3; endproperty
   property p_irq_rise; $rose(irq_out) |-> $past(illegal_access_in, 2); endproperty
   property p_clr_raw; s_w1c(8'h04) |-> ##2 !irq_out; endproperty
   property p_clr_mask; s_w1c(8'h08) |-> ##2 !irq_out; endproperty
   property p_phy; write_in && addr_in == 8'h14 |-> ##2 read_latency_out == $past(wdata_in[2:0], 2)
      && strobe_gating_select_out == $past(wdata_in[7], 2); endproperty
   property p_cal; s_wcal and wdata_in[17:16] != 2'h3 |-> ##2 filter_ctrl_out == $past(wdata_in[2:0], 2)
      && drive_strength_out == $past(wdata_in[5:3], 2) && ref_level_select_out == $past(wdata_in[17:16], 2);
   endproperty
   property p_ref_rsv; s_wcal and wdata_in[17:16] == 2'h3 |-> ##2 ref_level_select_out == $past(ref_level_select_out);
   endproperty
   property p_unmapped; read_in && addr_in > 8'h18 |=> rdata_out == 32'h0; endproperty
   a_count: assert property (p_count) else $error("elapsed count step wrong");
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose without trap");
   a_clr_raw: assert property (p_clr_raw) else $error("irq stayed after raw clear");
   a_clr_mask: assert property (p_clr_mask) else $error("irq stayed after masked clear");
   a_phy: assert property (p_phy) else $error("phy outputs wrong");
   a_cal: assert property (p_cal) else $error("calibration outputs wrong");
   a_ref_rsv: assert property (p_ref_rsv) else $error("reserved level taken");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind memctl_status_irq_phy_regs memctl_regs_asserts chk_u (.clock_in(clock_in), .arst_n_in(arst_n_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
   .illegal_access_in(illegal_access_in), .irq_out(irq_out), .read_latency_out(read_latency_out),
   .strobe_gating_select_out(strobe_gating_select_out), .ref_level_select_out(ref_level_select_out),
   .drive_strength_out(drive_strength_out), .filter_ctrl_out(filter_ctrl_out));
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the register group.
// Assumes the design and its constants header are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
   // ==========================================
   // Signals
   logic clock_in = 1'b0, arst_n_in = 1'b0, write_in = 1'b0, read_in = 1'b0, illegal_access_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0, rdata_out, e0, d, p;
   logic irq_out, strobe_gating_select_out, receiver_powerdown_out, internal_ref_enable_out;
   logic calibration_clear_n_out, calibration_power_save_out, impedance_lock_out, calibration_powerdown_out;
   logic [2:0] read_latency_out, drive_strength_out, filter_ctrl_out;
   logic [1:0] ref_level_select_out;
   logic [3:0] drive_force_out;
   integer err_count = 0, checked = 0, seed = 74, i;
   localparam logic [2:0] cas_lat = 3'h3;
   function logic [31:0] exp_phy(input logic [31:0] v);
      exp_phy = v & 32'h0000_00C7;
   endfunction
   memctl_status_irq_phy_regs dut_u (.clock_in(clock_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
      .illegal_access_in(illegal_access_in), .irq_out(irq_out), .read_latency_out(read_latency_out),
      .strobe_gating_select_out(strobe_gating_select_out), .receiver_powerdown_out(receiver_powerdown_out),
      .internal_ref_enable_out(internal_ref_enable_out), .ref_level_select_out(ref_level_select_out),
      .calibration_clear_n_out(calibration_clear_n_out), .drive_force_out(drive_force_out),
      .calibration_power_save_out(calibration_power_save_out), .impedance_lock_out(impedance_lock_out),
      .calibration_powerdown_out(calibration_powerdown_out), .drive_strength_out(drive_strength_out),
      .filter_ctrl_out(filter_ctrl_out));
   // ==========================================
   // Clock, tasks
   initial begin
      forever #2 clock_in = ~clock_in;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock_in);
      write_in <= 1'b1;
      addr_in <= a;
      wdata_in <= v;
      @(posedge clock_in);
      write_in <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock_in);
      read_in <= 1'b1;
      addr_in <= a;
      @(posedge clock_in);
      read_in <= 1'b0;
      @(posedge clock_in);
      v = rdata_out;
   endtask
   task ev;
      @(posedge clock_in);
      illegal_access_in <= 1'b1;
      @(posedge clock_in);
      illegal_access_in <= 1'b0;
   endtask
   task test_done;
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ==========================================
   // Tests
   initial begin
      #200000;
      err_count = err_count + 1;
      test_done;
   end
   initial begin
      repeat (20) @(posedge clock_in);
      arst_n_in <= 1'b1;
      for (i = 1; i < 6; i = i + 1) begin
         rd(8'(i * 4), d);
         check(d, 32'h0);
      end
      rd(8'h18, d);
      check(d, 32'h0000_0077);
      $display("reset values done");
      rd(8'h00, e0);
      rd(8'h00, d);
      check(d, e0 + 32'h3);
      wr(8'h00, $random(seed));
      rd(8'h00, d);
      check(d, e0 + 32'h8);
      $display("elapsed counter done");
      ev;
      rd(8'h04, d);
      check(d, 32'h4);
      rd(8'h08, d);
      check(d, 32'h0);
      check(32'(irq_out), 32'h0);
      wr(8'h04, 32'h0);
      rd(8'h04, d);
      check(d, 32'h4);
      wr(8'h04, 32'h4);
      rd(8'h04, d);
      check(d, 32'h0);
      wr(8'h0C, 32'h4);
      rd(8'h10, d);
      check(d, 32'h4);
      rd(8'h0C, d);
      check(d, 32'h4);
      ev;
      rd(8'h08, d);
      check(d, 32'h4);
      check(32'(irq_out), 32'h1);
      wr(8'h08, 32'h4);
      rd(8'h04, d);
      check(d, 32'h0);
      check(32'(irq_out), 32'h0);
      wr(8'h10, 32'h4);
      rd(8'h0C, d);
      check(d, 32'h0);
      ev;
      rd(8'h08, d);
      check(d, 32'h0);
      $display("trap flags done");
      for (i = 0; i < 4; i = i + 1) begin
         p = $random(seed);
         p[2:0] = cas_lat + 3'h1 + {2'h0, p[3]};
         wr(8'h14, p);
         rd(8'h14, d);
         check(d, exp_phy(p));
         check(32'({strobe_gating_select_out, read_latency_out}), 32'({p[7], p[2:0]}));
         d = $random(seed) & 32'h0005_5FFF;
         wr(8'h18, d);
         rd(8'h18, e0);
         check(e0, d);
         check(32'({internal_ref_enable_out, ref_level_select_out, calibration_clear_n_out, drive_force_out,
            calibration_power_save_out, impedance_lock_out, calibration_powerdown_out, drive_strength_out,
            filter_ctrl_out}), 32'({d[18:16], d[13:0]}));
         check(32'(receiver_powerdown_out), 32'(p[6] & d[14]));
      end
      $display("phy and calibration fields done");
      wr(8'h18, 32'h0000_2000);
      repeat (12) @(posedge clock_in);
      rd(8'h18, d);
      check(d, 32'h0000_A000);
      wr(8'h18, 32'h0005_0000);
      rd(8'h18, d);
      check(d, 32'h0005_0000);
      wr(8'h18, 32'h0007_0000);
      rd(8'h18, d);
      check(d, 32'h0005_0000);
      rd(8'h1C, d);
      check(d, 32'h0);
      rd(8'hFC, d);
      check(d, 32'h0);
      $display("ready, reference and unmapped done");
      test_done;
   end
endmodule
`default_nettype wire

// [rtl/memctl_regs_defines.vh]
// Constants for the memory controller status, interrupt and PHY register group.
// Assumes inclusion by bare name from the design file.
`ifndef MEMCTL_REGS_DEFINES_VH
`define MEMCTL_REGS_DEFINES_VH

// ==========================================
// Register offsets (byte addresses)
`define ADDR_ELAPSED 8'h00
`define ADDR_IRQ_RAW 8'h04
`define ADDR_IRQ_MASKED 8'h08
`define ADDR_IRQ_EN_SET 8'h0C
`define ADDR_IRQ_EN_CLR 8'h10
`define ADDR_PHY_READ 8'h14
`define ADDR_IO_CAL 8'h18

// ==========================================
// Field positions
`define TRAP_BIT 2
`define PHY_GATE_BIT 7
`define PHY_PDN_BIT 6
`define PHY_RL_MSB 2
`define CAL_REF_EN_BIT 18
`define CAL_REF_SEL_MSB 17
`define CAL_REF_SEL_LSB 16
`define CAL_READY_BIT 15
`define CAL_IBUF_PERMIT_BIT 14
`define CAL_CLEAR_N_BIT 13
`define CAL_FORCE_MSB 12
`define CAL_FORCE_LSB 9
`define CAL_PSAVE_BIT 8
`define CAL_LOCK_BIT 7
`define CAL_PDN_BIT 6
`define CAL_DRIVE_MSB 5
`define CAL_DRIVE_LSB 3
`define CAL_FILTER_MSB 2

// ==========================================
// Reset values, calibration write mask and reserved reference code
`define PHY_READ_RESET 32'h0000_0000
`define IO_CAL_RESET 32'h0000_0077
`define IO_CAL_WMASK 32'h0007_7FFF
`define REF_SEL_RESERVED 2'h3

// ==========================================
// Timing
`define CAL_SETTLE_CYCLES 8'h08

`endif

// [rtl/memctl_status_irq_phy_regs.v]
// Status, line-trap interrupt, PHY read control and I/O calibration registers.
// Assumes a single-cycle register port and a same-clock trap pulse from the controller.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "memctl_regs_defines.vh"

module memctl_status_irq_phy_regs #(
   parameter CAL_SETTLE = `CAL_SETTLE_CYCLES
) (
   // Clock and reset
   input wire clock_in,
   input wire arst_n_in,
   // Register port
   input wire [7:0] addr_in,
   input wire [31:0] wdata_in,
   input wire write_in,
   input wire read_in,
   output reg [31:0] rdata_out,
   // Controller events
   input wire illegal_access_in,
   // Interrupt
   output reg irq_out,
   // PHY controls
   output reg [2:0] read_latency_out,
   output reg strobe_gating_select_out,
   output reg receiver_powerdown_out,
   // Calibration controls
   output reg internal_ref_enable_out,
   output reg [1:0] ref_level_select_out,
   output reg calibration_clear_n_out,
   output reg [3:0] drive_force_out,
   output reg calibration_power_save_out,
   output reg impedance_lock_out,
   output reg calibration_powerdown_out,
   output reg [2:0] drive_strength_out,
   output reg [2:0] filter_ctrl_out
);

   // ==========================================
   // State
   reg [31:0] elapsed_reg;
   reg [31:0] elapsed_next;
   reg trap_raw_reg;
   reg trap_raw_next;
   reg trap_masked_reg;
   reg trap_masked_next;
   reg trap_enable_reg;
   reg trap_enable_next;
   reg [31:0] phy_reg;
   reg [31:0] phy_next;
   reg [31:0] cal_reg;
   reg [31:0] cal_next;
   reg cal_ready_reg;
   reg cal_ready_next;
   reg [7:0] settle_reg;
   reg [7:0] settle_next;
   reg [31:0] rd_next;

   // ==========================================
   // Address decode
   wire hit_raw = addr_in == `ADDR_IRQ_RAW;
   wire hit_masked = addr_in == `ADDR_IRQ_MASKED;
   wire hit_en_set = addr_in == `ADDR_IRQ_EN_SET;
   wire hit_en_clr = addr_in == `ADDR_IRQ_EN_CLR;
   wire hit_phy = addr_in == `ADDR_PHY_READ;
   wire hit_cal = addr_in == `ADDR_IO_CAL;
   wire wr_one = write_in && wdata_in[`TRAP_BIT];
   wire wr_raw = wr_one && hit_raw;
   wire wr_msk = wr_one && hit_masked;
   wire wr_set = wr_one && hit_en_set;
   wire wr_clr = wr_one && hit_en_clr;
   wire wr_phy = write_in && hit_phy;
   wire wr_cal = write_in && hit_cal;
   wire trap_clear = wr_raw || wr_msk;
   wire trap_event = illegal_access_in;
   wire trap_masked_event = trap_event && trap_enable_reg;
   wire cal_run = cal_reg[`CAL_CLEAR_N_BIT] && !cal_reg[`CAL_PDN_BIT];
   wire settle_done = settle_reg == CAL_SETTLE[7:0];

   // ==========================================
   // Elapsed counter
   always @* begin
      if (elapsed_reg == 32'hFFFF_FFFF) begin
         elapsed_next = 32'h0000_0000;
      end else begin
         elapsed_next = elapsed_reg + 32'h0000_0001;
      end
   end

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         elapsed_reg <= 32'h0000_0000;
      end else begin
         elapsed_reg <= elapsed_next;
      end
   end

   // ==========================================
   // Line trap flags and enable
   always @* begin
      trap_raw_next = trap_raw_reg;
      trap_masked_next = trap_masked_reg;
      trap_enable_next = trap_enable_reg;
      if (trap_clear) begin
         trap_raw_next = 1'h0;
         trap_masked_next = 1'h0;
      end
      if (trap_event) begin
         trap_raw_next = 1'h1;
      end
      if (trap_masked_event) begin
         trap_masked_next = 1'h1;
      end
      if (wr_set) begin
         trap_enable_next = 1'h1;
      end
      if (wr_clr) begin
         trap_enable_next = 1'h0;
      end
   end

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         trap_raw_reg <= 1'h0;
         trap_masked_reg <= 1'h0;
         trap_enable_reg <= 1'h0;
      end else begin
         trap_raw_reg <= trap_raw_next;
         trap_masked_reg <= trap_masked_next;
         trap_enable_reg <= trap_enable_next;
      end
   end

   // ==========================================
   // PHY read control
   always @* begin
      phy_next = phy_reg;
      if (wr_phy) begin
         phy_next = 32'h0000_0000;
         phy_next[`PHY_GATE_BIT] = wdata_in[`PHY_GATE_BIT];
         phy_next[`PHY_PDN_BIT] = wdata_in[`PHY_PDN_BIT];
         phy_next[`PHY_RL_MSB:0] = wdata_in[`PHY_RL_MSB:0];
      end
   end

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         phy_reg <= `PHY_READ_RESET;
      end else begin
         phy_reg <= phy_next;
      end
   end

   // ==========================================
   // I/O calibration control
   always @* begin
      cal_next = cal_reg;
      if (wr_cal) begin
         cal_next = 32'h0000_0000;
         cal_next[`CAL_REF_EN_BIT] = wdata_in[`CAL_REF_EN_BIT];
         if (wdata_in[`CAL_REF_SEL_MSB:`CAL_REF_SEL_LSB] == `REF_SEL_RESERVED) begin
            cal_next[`CAL_REF_SEL_MSB:`CAL_REF_SEL_LSB] = cal_reg[`CAL_REF_SEL_MSB:`CAL_REF_SEL_LSB];
         end else begin
            cal_next[`CAL_REF_SEL_MSB:`CAL_REF_SEL_LSB] = wdata_in[`CAL_REF_SEL_MSB:`CAL_REF_SEL_LSB];
         end
         cal_next[`CAL_IBUF_PERMIT_BIT] = wdata_in[`CAL_IBUF_PERMIT_BIT];
         cal_next[`CAL_CLEAR_N_BIT] = wdata_in[`CAL_CLEAR_N_BIT];
         cal_next[`CAL_FORCE_MSB:`CAL_FORCE_LSB] = wdata_in[`CAL_FORCE_MSB:`CAL_FORCE_LSB];
         cal_next[`CAL_PSAVE_BIT] = wdata_in[`CAL_PSAVE_BIT];
         cal_next[`CAL_LOCK_BIT] = wdata_in[`CAL_LOCK_BIT];
         cal_next[`CAL_PDN_BIT] = wdata_in[`CAL_PDN_BIT];
         cal_next[`CAL_DRIVE_MSB:`CAL_DRIVE_LSB] = wdata_in[`CAL_DRIVE_MSB:`CAL_DRIVE_LSB];
         cal_next[`CAL_FILTER_MSB:0] = wdata_in[`CAL_FILTER_MSB:0];
      end
   end

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cal_reg <= `IO_CAL_RESET;
      end else begin
         cal_reg <= cal_next;
      end
   end

   // ==========================================
   // Calibration progress
   always @* begin
      settle_next = settle_reg;
      cal_ready_next = cal_ready_reg;
      if (!cal_run) begin
         settle_next = 8'h00;
         cal_ready_next = 1'h0;
      end else if (settle_done) begin
         cal_ready_next = 1'h1;
      end else begin
         settle_next = settle_reg + 8'h01;
      end
   end

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         settle_reg <= 8'h00;
         cal_ready_reg <= 1'h0;
      end else begin
         settle_reg <= settle_next;
         cal_ready_reg <= cal_ready_next;
      end
   end

   // ==========================================
   // Read data
   always @* begin
      rd_next = 32'h0000_0000;
      case (addr_in)
         `ADDR_ELAPSED: begin
            rd_next = elapsed_reg;
         end
         `ADDR_IRQ_RAW: begin
            rd_next[`TRAP_BIT] = trap_raw_reg;
         end
         `ADDR_IRQ_MASKED: begin
            rd_next[`TRAP_BIT] = trap_masked_reg;
         end
         `ADDR_IRQ_EN_SET: begin
            rd_next[`TRAP_BIT] = trap_enable_reg;
         end
         `ADDR_IRQ_EN_CLR: begin
            rd_next[`TRAP_BIT] = trap_enable_reg;
         end
         `ADDR_PHY_READ: begin
            rd_next = phy_reg;
         end
         `ADDR_IO_CAL: begin
            rd_next = cal_reg;
            rd_next[`CAL_READY_BIT] = cal_ready_reg;
         end
         default: begin
            rd_next = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rdata_out <= 32'h0000_0000;
      end else if (read_in) begin
         rdata_out <= rd_next;
      end else begin
         rdata_out <= 32'h0000_0000;
      end
   end

   // ==========================================
   // Interrupt output
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_out <= 1'h0;
      end else begin
         irq_out <= trap_masked_reg;
      end
   end

   // ==========================================
   // PHY outputs
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         read_latency_out <= 3'h0;
         strobe_gating_select_out <= 1'h0;
         receiver_powerdown_out <= 1'h0;
      end else begin
         read_latency_out <= phy_reg[`PHY_RL_MSB:0];
         strobe_gating_select_out <= phy_reg[`PHY_GATE_BIT];
         receiver_powerdown_out <= phy_reg[`PHY_PDN_BIT] && cal_reg[`CAL_IBUF_PERMIT_BIT];
      end
   end

   // ==========================================
   // Reference outputs
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         internal_ref_enable_out <= 1'h0;
         ref_level_select_out <= 2'h0;
      end else begin
         internal_ref_enable_out <= cal_reg[`CAL_REF_EN_BIT];
         ref_level_select_out <= cal_reg[`CAL_REF_SEL_MSB:`CAL_REF_SEL_LSB];
      end
   end

   // ==========================================
   // Clear and force outputs
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         calibration_clear_n_out <= 1'h0;
         drive_force_out <= 4'h0;
      end else begin
         calibration_clear_n_out <= cal_reg[`CAL_CLEAR_N_BIT];
         drive_force_out <= cal_reg[`CAL_FORCE_MSB:`CAL_FORCE_LSB];
      end
   end

   // ==========================================
   // Power and lock outputs
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         calibration_power_save_out <= 1'h0;
         impedance_lock_out <= 1'h0;
         calibration_powerdown_out <= 1'h1;
      end else begin
         calibration_power_save_out <= cal_reg[`CAL_PSAVE_BIT];
         impedance_lock_out <= cal_reg[`CAL_LOCK_BIT];
         calibration_powerdown_out <= cal_reg[`CAL_PDN_BIT];
      end
   end

   // ==========================================
   // Drive and filter outputs
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         drive_strength_out <= 3'h6;
         filter_ctrl_out <= 3'h7;
      end else begin
         drive_strength_out <= cal_reg[`CAL_DRIVE_MSB:`CAL_DRIVE_LSB];
         filter_ctrl_out <= cal_reg[`CAL_FILTER_MSB:0];
      end
   end

endmodule
`default_nettype wire
